// ---- rtl/xdec_pkg.sv ----
`default_nettype none

package xdec_pkg;
  // ==========================================================
  // instruction cycle timing
  localparam logic [1:0] Q_LAST = 2'h3;  // q4 of the cycle

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ACC    = 8'h0c;
  localparam logic [7:0] OFS_BSR    = 8'h10;
  localparam logic [7:0] OFS_FSR [3] = '{8'h14, 8'h18, 8'h1c};
  localparam logic [7:0] OFS_PC     = 8'h20;
  localparam logic [7:0] OFS_RSTK   = 8'h24;
  localparam logic [7:0] OFS_MADDR  = 8'h28;
  localparam logic [7:0] OFS_MDATA  = 8'h2c;

  // ==========================================================
  // status field positions
  localparam int ST_Z_BIT    = 2;
  localparam int ST_N_BIT    = 3;
  localparam int ST_SKIP_BIT = 4;
  localparam int ST_MV_BIT   = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_ACC = 8'h00;
  localparam logic [3:0]  RST_BSR = 4'h0;
  localparam logic [11:0] RST_FSR = 12'h000;
  localparam logic [15:0] RST_PC  = 16'h0000;

  // ==========================================================
  // opcodes and address split points
  localparam logic [6:0]  OP_TST    = 7'h33;   // 0110 011a
  localparam logic [7:0]  OP_XOR_LITERAL_INTO_ACC  = 8'h0a;   // 0000 1010
  localparam logic [5:0]  OP_XOR_ACC_WITH_REGISTER  = 6'h06;   // 0001 10da
  localparam logic [6:0]  OP_FSRADJ = 7'h74;   // 1110 100s
  localparam logic [15:0] OP_CALL_VIA_ACCUMULATOR  = 16'h0014;
  localparam logic [7:0]  OP_MOVE   = 8'heb;
  localparam logic [7:0]  OP_PUSH_LITERAL_FRAME  = 8'hea;
  localparam logic [3:0]  OP_SECOND = 4'hf;
  localparam logic [1:0]  FRAME_SEL = 2'h3;
  localparam logic [7:0]  INDEX_LIMIT  = 8'h5f;  // 95
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]  ACCESS_HI    = 4'hf;
  localparam int          STK_DEPTH    = 4;
  localparam int          DMEM_WORDS   = 4096;

  // ==========================================================
  // execution states, gray along idle-exec-extra
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_EXEC  = 2'h1,
    ST_EXTRA = 2'h3
  } exec_state_e;
endpackage

`default_nettype wire

// ---- rtl/dp_if.sv ----
`default_nettype none

// ==========================================================
// datapath carrier between the core and its helpers
interface dp_if;
  logic [7:0]  opa;   // accumulator side
  logic [7:0]  opb;   // literal or register side
  logic [7:0]  res;   // xor result
  logic        neg;   // result bit 7
  logic        zero;  // result is zero
  logic [7:0]  f;     // register field
  logic        a;     // bank bit
  logic [3:0]  bank_select_reg;   // bank select
  logic [11:0] stack_frame_pointer;  // frame pointer
  logic        ext;   // extension enabled
  logic [11:0] eff;   // effective address
  modport alu  (input opa, opb, output res, neg, zero);
  modport addr (input f, a, bank_select_reg, stack_frame_pointer, ext, output eff);
  modport core (output opa, opb, f, a, bank_select_reg, stack_frame_pointer, ext,
                input res, neg, zero, eff);
endinterface

`default_nettype wire

// ---- rtl/xor_flag_unit.sv ----
`default_nettype none

// ==========================================================
// xor with negative and zero results, nothing else
module xor_flag_unit (
  // datapath
  dp_if.alu dp
);
  always_comb begin
    dp.res  = dp.opa ^ dp.opb;
    dp.neg  = dp.res[7];
    dp.zero = (dp.res == 8'h00);
  end
endmodule

`default_nettype wire

// ---- rtl/frame_addr_unit.sv ----
`default_nettype none

// ==========================================================
// data address: access bank, banked, or frame indexed
module frame_addr_unit (
  // datapath
  dp_if.addr dp
);
  always_comb begin
    if (dp.a) begin
      dp.eff = {dp.bank_select_reg, dp.f};
    end else if (dp.ext && dp.f <= xdec_pkg::INDEX_LIMIT) begin
      dp.eff = dp.stack_frame_pointer + {4'h0, dp.f};
    end else if (dp.f < xdec_pkg::ACCESS_SPLIT) begin
      dp.eff = {4'h0, dp.f};
    end else begin
      dp.eff = {xdec_pkg::ACCESS_HI, dp.f};
    end
  end
endmodule

`default_nettype wire

// ---- rtl/xor_skip_extended_decoder.sv ----
`default_nettype none

module xor_skip_extended_decoder (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  // apb answer
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);
  // ==========================================================
  // state
  xdec_pkg::exec_state_e state;       // execution phase
  logic [1:0]  q;                     // q1..q4 within a cycle
  logic [15:0] ir;                    // word being executed
  logic        ext;                   // extension_enable_config
  logic [7:0]  acc;                   // accumulator
  logic [3:0]  bank_select_reg;                   // bank_select_reg
  logic [11:0] file_select_pointer [3];               // file_select_pointer 0..2
  logic [15:0] pc;                    // program counter
  logic        flag_n;                // negative
  logic        flag_z;                // zero
  logic        skip;                  // discard next word
  logic        mv_first;              // first move word seen
  logic        mv_idx;                // move destination indexed
  logic [7:0]  mv_data;               // byte read by first word
  logic [15:0] rstk [xdec_pkg::STK_DEPTH]; // return stack
  logic [2:0]  sp;                    // stack fill level
  logic [11:0] maddr;                 // software memory pointer
  logic [7:0]  dmem [xdec_pkg::DMEM_WORDS]; // data memory

  // ==========================================================
  // helpers
  dp_if dp ();
  xor_flag_unit u_alu (
    .dp (dp)
  );
  frame_addr_unit u_addr (
    .dp (dp)
  );

  logic        busy;      // an instruction is in flight
  logic        end_cyc;   // last q of an execute cycle
  logic        normal;    // word not skipped, not a move tail
  logic [7:0]  k;         // literal field
  logic [7:0]  mem_rd;    // register operand
  logic [15:0] return_stack_top;       // return_stack_top
  logic        is_tst;
  logic        is_xor_literal_into_acc;
  logic        is_xor_acc_with_register;
  logic        is_adj;
  logic        is_call_via_accumulator;
  logic        is_mv1;
  logic        is_push_literal_frame;
  logic        is_second;
  logic [1:0]  sel;       // pointer select field
  logic [11:0] adj_base;
  logic [11:0] adj_k;
  logic [11:0] mv_src;    // frame-indexed move source
  logic [11:0] mv_dst;    // move destination

  assign busy    = (state != xdec_pkg::ST_IDLE);
  assign end_cyc = (state == xdec_pkg::ST_EXEC) && (q == xdec_pkg::Q_LAST);
  assign normal  = !skip && !mv_first;
  assign k       = ir[7:0];
  assign sel     = ir[7:6];
  assign return_stack_top     = rstk[2'(sp - 3'h1)];

  assign dp.opa  = acc;
  assign dp.opb  = is_xor_literal_into_acc ? k : mem_rd;
  assign dp.f    = ir[7:0];
  assign dp.a    = ir[8];
  assign dp.bank_select_reg  = bank_select_reg;
  assign dp.stack_frame_pointer = file_select_pointer[2];
  assign dp.ext  = ext;
  assign mem_rd  = dmem[dp.eff];

  // ==========================================================
  // decode; extended opcodes need the configuration bit
  always_comb begin
    is_tst    = (ir[15:9] == xdec_pkg::OP_TST);
    is_xor_literal_into_acc  = (ir[15:8] == xdec_pkg::OP_XOR_LITERAL_INTO_ACC);
    is_xor_acc_with_register  = (ir[15:10] == xdec_pkg::OP_XOR_ACC_WITH_REGISTER);
    is_adj    = ext && (ir[15:9] == xdec_pkg::OP_FSRADJ);
    is_call_via_accumulator  = ext && (ir == xdec_pkg::OP_CALL_VIA_ACCUMULATOR);
    is_mv1    = ext && (ir[15:8] == xdec_pkg::OP_MOVE);
    is_push_literal_frame  = ext && (ir[15:8] == xdec_pkg::OP_PUSH_LITERAL_FRAME);
    is_second = (ir[15:12] == xdec_pkg::OP_SECOND);
  end

  // pointer arithmetic; literal is zero-extended, never signed
  always_comb begin
    adj_base = (sel == xdec_pkg::FRAME_SEL) ? file_select_pointer[2] : file_select_pointer[sel];
    adj_k    = {6'h00, ir[5:0]};
    mv_src   = file_select_pointer[2] + {5'h00, ir[6:0]};
    mv_dst   = mv_idx ? mv_src : ir[11:0];
  end

  // ==========================================================
  // execute: everything commits at q4 of the cycle
  logic [7:0]  next_acc;
  logic        next_n;
  logic        next_z;
  logic [15:0] next_pc;
  logic        next_skip;
  logic        next_mv;
  logic        go_extra;
  logic        do_push;
  logic        do_pop;
  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;
  logic [2:0]  fsr_we;
  logic [11:0] fsr_wd;

  always_comb begin
    next_acc  = acc;
    next_n    = flag_n;
    next_z    = flag_z;
    next_pc   = pc + 16'h0001;
    next_skip = 1'b0;
    next_mv   = 1'b0;
    go_extra  = 1'b0;
    do_push   = 1'b0;
    do_pop    = 1'b0;
    mem_we    = 1'b0;
    mem_wa    = dp.eff;
    mem_wd    = dp.res;
    fsr_we    = 3'h0;
    fsr_wd    = ir[8] ? adj_base - adj_k : adj_base + adj_k;
    if (skip) begin
      // discarded word runs as nop; a move head drags its tail
      next_skip = is_mv1;
    end else if (mv_first) begin
      // move tail: write the byte latched by the head word
      if (is_second) begin
        mem_we = 1'b1;
        mem_wa = mv_dst;
        mem_wd = mv_data;
      end
    end else if (is_tst) begin
      next_skip = (mem_rd == 8'h00);
    end else if (is_xor_literal_into_acc || is_xor_acc_with_register) begin
      next_n = dp.neg;
      next_z = dp.zero;
      if (is_xor_literal_into_acc || !ir[9]) begin
        next_acc = dp.res;
      end else begin
        mem_we = 1'b1;
      end
    end else if (is_adj) begin
      if (sel == xdec_pkg::FRAME_SEL) begin
        fsr_we[2] = 1'b1;
        do_pop    = 1'b1;
        next_pc   = return_stack_top;
        go_extra  = 1'b1;
      end else begin
        fsr_we[sel] = 1'b1;
      end
    end else if (is_call_via_accumulator) begin
      do_push  = 1'b1;
      next_pc  = {pc[15:8], acc};
      go_extra = 1'b1;
    end else if (is_mv1) begin
      next_mv = 1'b1;
    end else if (is_push_literal_frame) begin
      mem_we    = 1'b1;
      mem_wa    = file_select_pointer[2];
      mem_wd    = k;
      fsr_we[2] = 1'b1;
      fsr_wd    = file_select_pointer[2] - 12'h001;
    end
    // a lone 1111 word and anything undecoded fall through as nop
  end

  // ==========================================================
  // apb slave: one wait state, answer registered
  logic        acc_phase;  // first access cycle
  logic        apb_wr;     // write commits this edge
  logic        mapped;     // address decodes
  logic        wr_ok;      // register write allowed
  logic        wr_instr;   // new word accepted
  logic [31:0] rd_mux;

  assign acc_phase = psel && penable && !pready;
  assign apb_wr    = psel && penable && pwrite && pready;
  // commit only what the answer did not refuse, so a write that met
  // busy at its access edge stays dropped even if busy ends just then
  assign wr_ok     = apb_wr && !pslverr;
  assign wr_instr  = wr_ok && (paddr == xdec_pkg::OFS_INSTR);

  // read mux; also flags unmapped offsets
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      xdec_pkg::OFS_INSTR:  rd_mux = {16'h0000, ir};
      xdec_pkg::OFS_CTRL:   rd_mux = {31'h0, ext};
      xdec_pkg::OFS_STATUS: begin
        rd_mux[1:0]                  = state;
        rd_mux[xdec_pkg::ST_Z_BIT]    = flag_z;
        rd_mux[xdec_pkg::ST_N_BIT]    = flag_n;
        rd_mux[xdec_pkg::ST_SKIP_BIT] = skip;
        rd_mux[xdec_pkg::ST_MV_BIT]   = mv_first;
      end
      xdec_pkg::OFS_ACC:    rd_mux = {24'h0, acc};
      xdec_pkg::OFS_BSR:    rd_mux = {28'h0, bank_select_reg};
      xdec_pkg::OFS_FSR[0]: rd_mux = {20'h0, file_select_pointer[0]};
      xdec_pkg::OFS_FSR[1]: rd_mux = {20'h0, file_select_pointer[1]};
      xdec_pkg::OFS_FSR[2]: rd_mux = {20'h0, file_select_pointer[2]};
      xdec_pkg::OFS_PC:     rd_mux = {16'h0, pc};
      xdec_pkg::OFS_RSTK:   rd_mux = {16'h0, return_stack_top};
      xdec_pkg::OFS_MADDR:  rd_mux = {20'h0, maddr};
      xdec_pkg::OFS_MDATA:  rd_mux = {24'h0, dmem[maddr]};
      default:              mapped = 1'b0;
    endcase
  end

  // answer: writes while busy are refused so state stays coherent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_phase;
      pslverr <= acc_phase && (!mapped || (pwrite && busy));
      prdata  <= (acc_phase && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // sequencer: four clocks per instruction cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= xdec_pkg::ST_IDLE;
      q     <= 2'h0;
    end else if (wr_instr) begin
      state <= xdec_pkg::ST_EXEC;
      q     <= 2'h0;
    end else if (busy) begin
      q <= q + 2'h1;
      if (q == xdec_pkg::Q_LAST) begin
        // second cycle of return or call is a plain nop
        state <= (end_cyc && go_extra) ? xdec_pkg::ST_EXTRA
                                       : xdec_pkg::ST_IDLE;
      end
    end
  end

  // instruction word and configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir  <= 16'h0000;
      ext <= 1'b0;
    end else begin
      if (wr_instr) ir <= pwdata[15:0];
      if (wr_ok && paddr == xdec_pkg::OFS_CTRL) ext <= pwdata[0];
    end
  end

  // working registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc      <= xdec_pkg::RST_ACC;
      bank_select_reg      <= xdec_pkg::RST_BSR;
      pc       <= xdec_pkg::RST_PC;
      flag_n   <= 1'b0;
      flag_z   <= 1'b0;
      skip     <= 1'b0;
      mv_first <= 1'b0;
      mv_idx   <= 1'b0;
      mv_data  <= 8'h00;
      maddr    <= 12'h000;
    end else if (end_cyc) begin
      acc      <= next_acc;
      pc       <= next_pc;
      flag_n   <= next_n;
      flag_z   <= next_z;
      skip     <= next_skip;
      mv_first <= next_mv;
      mv_idx   <= ir[7];
      mv_data  <= dmem[mv_src];
    end else if (wr_ok) begin
      if (paddr == xdec_pkg::OFS_ACC)   acc   <= pwdata[7:0];
      if (paddr == xdec_pkg::OFS_BSR)   bank_select_reg   <= pwdata[3:0];
      if (paddr == xdec_pkg::OFS_PC)    pc    <= pwdata[15:0];
      if (paddr == xdec_pkg::OFS_MADDR) maddr <= pwdata[11:0];
    end
  end

  // pointers, one per select code 0..2; code 3 also selects pointer 2
  for (genvar i = 0; i < 3; i++) begin : g_fsr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        file_select_pointer[i] <= xdec_pkg::RST_FSR;
      end else if (end_cyc && fsr_we[i]) begin
        file_select_pointer[i] <= fsr_wd;
      end else if (wr_ok && paddr == xdec_pkg::OFS_FSR[i]) begin
        file_select_pointer[i] <= pwdata[11:0];
      end
    end
  end

  // return stack; overflow drops the push, underflow holds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp <= 3'h0;
    end else if (end_cyc && do_pop && sp != 3'h0) begin
      sp <= sp - 3'h1;
    end else if ((end_cyc && do_push) ||
                 (wr_ok && paddr == xdec_pkg::OFS_RSTK)) begin
      if (sp != 3'(xdec_pkg::STK_DEPTH)) sp <= sp + 3'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (sp != 3'(xdec_pkg::STK_DEPTH)) begin
      if (end_cyc && do_push) rstk[sp[1:0]] <= pc + 16'h0001;
      else if (wr_ok && paddr == xdec_pkg::OFS_RSTK)
        rstk[sp[1:0]] <= pwdata[15:0];
    end
  end

  // data memory: execution wins, software only when idle
  always_ff @(posedge pclk) begin
    if (end_cyc && mem_we) dmem[mem_wa] <= mem_wd;
    else if (wr_ok && paddr == xdec_pkg::OFS_MDATA)
      dmem[maddr] <= pwdata[7:0];
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  skip_arm_a: assert property (end_cyc && normal && is_tst &&
    mem_rd == 8'h00 |=> skip)
    else $error("zero test did not arm skip");
  skip_nop_a: assert property (end_cyc && skip && !is_mv1
    |=> !skip && acc == $past(acc) && state == xdec_pkg::ST_IDLE)
    else $error("skipped word had an effect");
  xor_lit_a: assert property (end_cyc && normal && is_xor_literal_into_acc
    |=> acc == ($past(acc) ^ $past(k)))
    else $error("literal xor result wrong");
  xor_dest_a: assert property (end_cyc && normal && is_xor_acc_with_register
    && ir[9] |=> acc == $past(acc))
    else $error("register xor touched accumulator");
  xor_flags_a: assert property (end_cyc && normal
    && (is_xor_literal_into_acc || is_xor_acc_with_register)
    |=> flag_z == $past(dp.zero) && flag_n == $past(dp.neg))
    else $error("xor flags wrong");
  index_addr_a: assert property (ext && !ir[8]
    && ir[7:0] <= xdec_pkg::INDEX_LIMIT
    |-> dp.eff == file_select_pointer[2] + {4'h0, ir[7:0]})
    else $error("indexed address wrong");
  ext_gate_a: assert property (!ext
    |-> !(is_adj || is_call_via_accumulator || is_mv1 || is_push_literal_frame))
    else $error("extended opcode decoded while disabled");
  frame_ret_a: assert property (end_cyc && normal && is_adj
    && sel == xdec_pkg::FRAME_SEL
    |=> pc == $past(return_stack_top) ##0 (state == xdec_pkg::ST_EXTRA)[*4]
    ##1 state == xdec_pkg::ST_IDLE)
    else $error("frame return timing wrong");
  push_frame_a: assert property (end_cyc && normal && is_push_literal_frame
    |=> file_select_pointer[2] == $past(file_select_pointer[2]) - 12'h001)
    else $error("push did not decrement frame pointer");
endmodule

`default_nettype wire

// ---- tb/prog_stream_model.sv ----
`default_nettype none

// ==========================================================
// fetch stream: the words that follow a zero test
module prog_stream_model (
  // fetch slot
  input  wire logic [2:0]  slot,
  // word on the fetch bus
  output var  logic [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  // fixed program; past its end the stream holds plain nops
  always_comb begin
    case (slot)
      3'h0, 3'h2: word = 16'h6720;  // banked zero test
      3'h1: word = 16'h0a55;        // xor to be swallowed
      3'h3: word = 16'heb01;        // move head, swallowed
      3'h4: word = 16'hf030;        // its tail, swallowed too
      3'h5: word = 16'hf0ff;        // lone tail word
      default: word = 16'h0000;     // nop
    endcase
  end
endmodule

`default_nettype wire

// ---- tb/xor_skip_extended_decoder_tb_top.sv ----
`default_nettype none

`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, g, e); \
  end \
end

// ==========================================================
// bench top: apb driver notes answers, a watcher checks them
module xor_skip_extended_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [31:0] val;
    logic [31:0] mask;
    logic        err;
  } note_s;
  logic        pclk;     // 8 ns clock
  logic        presetn;  // async reset, low active
  logic        psel;     // apb request
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;   // apb answer
  logic        pready;
  logic        pslverr;
  logic [2:0]  slot;     // fetch stream position
  logic [15:0] word;
  logic [31:0] rdat;     // data taken by the driver
  logic [31:0] v;        // random operands
  logic [7:0]  k;
  logic [7:0]  r;
  note_s       notes[$]; // answers still awaited
  note_s       cur;
  int          polls;    // status reads until idle
  int          bad_count;
  int          tests_run;

  xor_skip_extended_decoder dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  prog_stream_model fetch (.slot(slot), .word(word));

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // ==========================================================
  // verdict, the single way out of the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one transfer; held until pready, then an idle cycle so no
  // signal is driven twice in one time step
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] e,
                    input logic [31:0] m, input logic er);
    int n;
    notes.push_back('{e, m, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 40) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    xf(1'b0, a, 32'h0, e, m, 1'b0);
  endtask

  // run one word, poll status until idle; polls shows the length
  task automatic ex(input logic [15:0] w);
    wr(xdec_pkg::OFS_INSTR, {16'h0, w});
    polls = 0;
    do begin
      rd(xdec_pkg::OFS_STATUS, 32'h0, 32'h0);
      polls++;
    end while (rdat[1:0] !== 2'h0 && polls < 20);
    if (polls >= 20) begin
      bad_count++;
      report_and_stop();
    end
  endtask

  task automatic mem(input logic [11:0] a, input logic [7:0] d);
    wr(xdec_pkg::OFS_MADDR, {20'h0, a});
    wr(xdec_pkg::OFS_MDATA, {24'h0, d});
  endtask

  task automatic mchk(input logic [11:0] a, input logic [7:0] e);
    wr(xdec_pkg::OFS_MADDR, {20'h0, a});
    rd(xdec_pkg::OFS_MDATA, {24'h0, e}, 32'hff);
  endtask

  // watcher: the oldest note meets each answer
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      cur = notes.pop_front();
      `CHK(pslverr, cur.err)
      if (cur.mask != 32'h0) `CHK(prdata & cur.mask, cur.val & cur.mask)
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slot} = '0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    void'($urandom(9441));
    // reset state, then an unmapped offset
    rd(xdec_pkg::OFS_ACC, 32'h0, 32'hff);
    rd(xdec_pkg::OFS_STATUS, 32'h0, 32'h3f);
    rd(xdec_pkg::OFS_FSR[2], 32'h0, 32'hfff);
    xf(1'b0, 8'h40, 32'h0, 32'h0, 32'h0, 1'b1);
    // literal xor on random operands, one equal pair for zero
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      k = (i == 0) ? v[7:0] : 8'($urandom);
      r = v[7:0] ^ k;
      wr(xdec_pkg::OFS_ACC, v & 32'hff);
      ex({8'h0a, k});
      `CHK(polls, 2)
      rd(xdec_pkg::OFS_ACC, r, 32'hff);
      rd(xdec_pkg::OFS_STATUS, {r[7], r == 8'h0, 2'h0}, 32'hc);
    end
    // a word written while busy is refused and dropped
    wr(xdec_pkg::OFS_ACC, 32'h0);
    wr(xdec_pkg::OFS_INSTR, 32'h0a0f);
    xf(1'b1, xdec_pkg::OFS_INSTR, 32'h0af0, 32'h0, 32'h0, 1'b1);
    ex(16'h0000);
    rd(xdec_pkg::OFS_ACC, 32'h0f, 32'hff);
    // register xor: banked to register, access bank to acc
    wr(xdec_pkg::OFS_BSR, 32'h3);
    mem(12'h340, 8'haf);
    mem(12'hf90, 8'h35);
    mem(12'h020, 8'h80);
    wr(xdec_pkg::OFS_ACC, 32'hb5);
    ex(16'h1b40);
    `CHK(polls, 2)
    mchk(12'h340, 8'h1a);
    ex(16'h1890);
    rd(xdec_pkg::OFS_ACC, 32'h80, 32'hff);
    rd(xdec_pkg::OFS_STATUS, 32'h8, 32'hc);
    mchk(12'hf90, 8'h35);
    ex(16'h1820);
    rd(xdec_pkg::OFS_STATUS, 32'h4, 32'hc);
    // frame indexing reaches offset 0x5f, not 0x60
    wr(xdec_pkg::OFS_CTRL, 32'h1);
    wr(xdec_pkg::OFS_FSR[2], 32'h200);
    wr(xdec_pkg::OFS_ACC, 32'hff);
    mem(12'h25f, 8'h0f);
    mem(12'h060, 8'h01);
    ex(16'h1a5f);
    ex(16'h1a60);
    mchk(12'h25f, 8'hf0);
    mchk(12'h060, 8'hfe);
    // pointer add and subtract on every pointer
    for (int f = 0; f < 3; f++) begin
      wr(xdec_pkg::OFS_FSR[f], 32'h3ff);
      ex({8'he8, f[1:0], 6'h23});
      `CHK(polls, 2)
      rd(xdec_pkg::OFS_FSR[f], 32'h422, 32'hfff);
      ex({8'he9, f[1:0], 6'h3f});
      rd(xdec_pkg::OFS_FSR[f], 32'h3e3, 32'hfff);
    end
    // frame adjust with return, both directions
    wr(xdec_pkg::OFS_RSTK, 32'h1234);
    ex(16'he8e3);
    `CHK(polls, 3)
    rd(xdec_pkg::OFS_FSR[2], 32'h406, 32'hfff);
    rd(xdec_pkg::OFS_PC, 32'h1234, 32'hffff);
    wr(xdec_pkg::OFS_RSTK, 32'h2000);
    ex(16'he9c1);
    rd(xdec_pkg::OFS_FSR[2], 32'h405, 32'hfff);
    rd(xdec_pkg::OFS_PC, 32'h2000, 32'hffff);
    // call through the accumulator
    wr(xdec_pkg::OFS_PC, 32'h0500);
    wr(xdec_pkg::OFS_ACC, 32'h77);
    ex(16'h0014);
    `CHK(polls, 3)
    rd(xdec_pkg::OFS_PC, 32'h0577, 32'hffff);
    rd(xdec_pkg::OFS_RSTK, 32'h0501, 32'hffff);
    // push literal, then both move forms from frame offset 5
    wr(xdec_pkg::OFS_FSR[2], 32'h300);
    ex(16'hea5a);
    `CHK(polls, 2)
    mchk(12'h300, 8'h5a);
    rd(xdec_pkg::OFS_FSR[2], 32'h2ff, 32'hfff);
    mem(12'h304, 8'h6c);
    ex(16'heb05);
    rd(xdec_pkg::OFS_STATUS, 32'h20, 32'h20);
    ex(16'hf123);
    mchk(12'h123, 8'h6c);
    ex(16'heb85);
    ex(16'hf007);
    mchk(12'h306, 8'h6c);
    // skips over one word and over a move, fed by the stream
    wr(xdec_pkg::OFS_BSR, 32'h0);
    mem(12'h020, 8'h00);
    mem(12'h030, 8'h44);
    wr(xdec_pkg::OFS_ACC, 32'h11);
    wr(xdec_pkg::OFS_PC, 32'h0100);
    for (int s = 0; s < 6; s++) begin
      slot <= s[2:0];
      @(posedge pclk);
      ex(word);
      if (s == 0) rd(xdec_pkg::OFS_STATUS, 32'h10, 32'h10);
    end
    rd(xdec_pkg::OFS_ACC, 32'h11, 32'hff);
    mchk(12'h030, 8'h44);
    rd(xdec_pkg::OFS_PC, 32'h0106, 32'hffff);
    mem(12'h020, 8'h01);
    ex(16'h6720);
    ex(16'h0a55);
    rd(xdec_pkg::OFS_ACC, 32'h44, 32'hff);
    // extension off: push literal is a nop
    wr(xdec_pkg::OFS_CTRL, 32'h0);
    mem(12'h2ff, 8'h00);
    ex(16'hea11);
    rd(xdec_pkg::OFS_FSR[2], 32'h2ff, 32'hfff);
    mchk(12'h2ff, 8'h00);
    report_and_stop();
  end
endmodule

`default_nettype wire
